// ===== logic/dbg_freeze_cfg.svh
/*
  register offsets, field positions and reset values of the debug freeze block.
  assumes inclusion by bare name from the design file.
*/
`ifndef DBG_FREEZE_CFG_SVH
`define DBG_FREEZE_CFG_SVH
`define OFS_PRIMARY      8'h04
`define OFS_SECONDARY    8'h08
`define RST_PRIMARY      32'h0000_0000
`define RST_SECONDARY    32'h0000_0000
`define MASK_PRIMARY     32'h0CB1_FB07
`define MASK_SECONDARY   32'h0003_0400
`define BIT_TMR_FOURTEEN 27
`define BIT_TMR_ELEVEN   26
`define BIT_TMR_EIGHT    23
`define BIT_TMR_SIX      21
`define BIT_TMR_FIVE     20
`define BIT_TW_ONE       16
`define BIT_TW_ZERO      15
`define BIT_CAN          14
`define BIT_TMR_TWO      13
`define BIT_TMR_ONE      12
`define BIT_TMR_ZERO     11
`define BIT_WWDG         9
`define BIT_FWDG         8
`define BIT_STANDBY      2
`define BIT_DEEPSLEEP    1
`define BIT_SLEEP        0
`define BIT_TW_TWO       17
`define BIT_LOWPOWER     16
`define BIT_RTC          10
`endif

// ===== logic/dbg_freeze_pkg.sv
/*
  types of the debug freeze block.
  assumes the cfg header is on the include path.
*/
package dbg_freeze_pkg;
  typedef enum logic [1:0] {
    mode_run,
    mode_sleep,
    mode_deepsleep,
    mode_standby
  } power_mode_t;

  typedef struct packed {
    logic freeze_tmr_fourteen;
    logic freeze_tmr_eleven;
    logic freeze_tmr_eight;
    logic freeze_tmr_six;
    logic freeze_tmr_five;
    logic freeze_tmr_two;
    logic freeze_tmr_one;
    logic freeze_tmr_zero;
    logic freeze_twowire_zero_state;
    logic freeze_twowire_one_timeout;
    logic freeze_twowire_two_state;
    logic freeze_can_counter;
    logic freeze_window_watchdog;
    logic freeze_free_watchdog;
    logic freeze_lowpower_counter;
    logic freeze_rtc_counter;
  } freeze_t;

  typedef struct packed {
    logic keep_clock_in_sleep;
    logic keep_clock_in_deepsleep;
    logic keep_clock_in_standby;
    logic use_internal_16mhz_oscillator;
    logic reset_on_standby_exit;
  } clock_keep_t;
endpackage

// ===== logic/debug_halt_freeze_control.sv
/*
  debug freeze control: two software hold registers, freeze strobes and
  clock-keep requests. assumes core_halted and power_mode come from other
  clock domains (synchronised here) and rstn is the power-on reset only.
*/
// The address-and-strobe port was left to the implementer.
// Operation
// - halted core with hold bit stops timer 11, 8 and 14 counters
// - halted core with hold bit freezes timer 6 and timer 5 counters
// - halted core with hold bit freezes timer 2, 1 and 0 counters
// - halted core with bit 15 holds two-wire 0 state against timeout
// - halted core with bit 16 suspends two-wire 1 timeout counting
// - halted core with bit 14 stops the CAN counter
// - halted core with bit 9 gates window watchdog counter clock
// - halted core with bit 8 gates free watchdog counter clock
// - standby with bit 2 keeps clocks on 16 MHz oscillator, reset on exit
// - deep-sleep with bit 1 keeps bus and system clocks on 16 MHz oscillator
// - sleep with bit 0 keeps the bus clock running
// - hold bits change only by software write; zero means no effect
// - secondary register at 0x08, resets to zero by power reset only
// - secondary bit 10 stops the RTC counter while halted
// - secondary bit 16 stops the low-power timer counter while halted
// - secondary bit 17 holds two-wire 2 state while halted
`timescale 1ns/10ps
`include "dbg_freeze_cfg.svh"

module debug_halt_freeze_control (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       rstn,
  input  wire logic                       clk_en,
  // register port
  input  wire logic [7:0]                 addr,
  input  wire logic [31:0]                wdata,
  input  wire logic                       wr_stb,
  input  wire logic                       rd_stb,
  output logic      [31:0]                rdata,
  // core and power state
  input  wire logic                       core_halted,
  input  wire dbg_freeze_pkg::power_mode_t power_mode,
  // controls out
  output dbg_freeze_pkg::freeze_t        freeze,
  output dbg_freeze_pkg::clock_keep_t    clock_keep
);
  import dbg_freeze_pkg::*;

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] sync1_nxt;
  logic [2:0] sync2_nxt;
  logic       halted_s;
  power_mode_t mode_s;

  always_comb begin
    sync1_nxt = {core_halted, power_mode};
    sync2_nxt = sync1_r;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else if (clk_en) begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  assign halted_s = sync2_r[2];
  assign mode_s   = power_mode_t'(sync2_r[1:0]);

  // ************************************************************
  // hold registers
  // ************************************************************
  logic [31:0] primary_r;
  logic [31:0] secondary_r;
  logic [31:0] rdata_r;
  logic [31:0] primary_nxt;
  logic [31:0] secondary_nxt;
  logic [31:0] rdata_nxt;

  // reserved bits are masked off so they always read back as zero
  always_comb begin
    primary_nxt   = primary_r;
    secondary_nxt = secondary_r;
    rdata_nxt     = 32'h0000_0000;
    if (wr_stb && addr == `OFS_PRIMARY) begin
      primary_nxt = wdata & `MASK_PRIMARY;
    end
    if (wr_stb && addr == `OFS_SECONDARY) begin
      secondary_nxt = wdata & `MASK_SECONDARY;
    end
    if (rd_stb) begin
      case (addr)
        `OFS_PRIMARY:   rdata_nxt = primary_r;
        `OFS_SECONDARY: rdata_nxt = secondary_r;
        default:        rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // only the power reset reaches this process; system reset is not wired in
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      primary_r   <= `RST_PRIMARY;
      secondary_r <= `RST_SECONDARY;
      rdata_r     <= 32'h0000_0000;
    end else if (clk_en) begin
      primary_r   <= primary_nxt;
      secondary_r <= secondary_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;

  // ************************************************************
  // freeze strobes and clock keep
  // ************************************************************
  freeze_t     freeze_r;
  freeze_t     freeze_nxt;
  clock_keep_t keep_r;
  clock_keep_t keep_nxt;
  logic        standby_seen_r;
  logic        standby_seen_nxt;
  logic [15:0] gate_out;

  // ************************************************************
  // per-unit freeze gates, bit order as the freeze struct
  // ************************************************************
  halt_gate #(
    .BIT_POS (`BIT_TMR_FOURTEEN)
  ) u_gate_tmr_fourteen (
    .halted    (halted_s),
    .hold_word (primary_r),
    .frozen    (gate_out[15])
  );

  halt_gate #(
    .BIT_POS (`BIT_TMR_ELEVEN)
  ) u_gate_tmr_eleven (
    .halted    (halted_s),
    .hold_word (primary_r),
    .frozen    (gate_out[14])
  );

  halt_gate #(
    .BIT_POS (`BIT_TMR_EIGHT)
  ) u_gate_tmr_eight (
    .halted    (halted_s),
    .hold_word (primary_r),
    .frozen    (gate_out[13])
  );

  halt_gate #(
    .BIT_POS (`BIT_TMR_SIX)
  ) u_gate_tmr_six (
    .halted    (halted_s),
    .hold_word (primary_r),
    .frozen    (gate_out[12])
  );

  halt_gate #(
    .BIT_POS (`BIT_TMR_FIVE)
  ) u_gate_tmr_five (
    .halted    (halted_s),
    .hold_word (primary_r),
    .frozen    (gate_out[11])
  );

  halt_gate #(
    .BIT_POS (`BIT_TMR_TWO)
  ) u_gate_tmr_two (
    .halted    (halted_s),
    .hold_word (primary_r),
    .frozen    (gate_out[10])
  );

  halt_gate #(
    .BIT_POS (`BIT_TMR_ONE)
  ) u_gate_tmr_one (
    .halted    (halted_s),
    .hold_word (primary_r),
    .frozen    (gate_out[9])
  );

  halt_gate #(
    .BIT_POS (`BIT_TMR_ZERO)
  ) u_gate_tmr_zero (
    .halted    (halted_s),
    .hold_word (primary_r),
    .frozen    (gate_out[8])
  );

  halt_gate #(
    .BIT_POS (`BIT_TW_ZERO)
  ) u_gate_tw_zero (
    .halted    (halted_s),
    .hold_word (primary_r),
    .frozen    (gate_out[7])
  );

  halt_gate #(
    .BIT_POS (`BIT_TW_ONE)
  ) u_gate_tw_one (
    .halted    (halted_s),
    .hold_word (primary_r),
    .frozen    (gate_out[6])
  );

  halt_gate #(
    .BIT_POS (`BIT_TW_TWO)
  ) u_gate_tw_two (
    .halted    (halted_s),
    .hold_word (secondary_r),
    .frozen    (gate_out[5])
  );

  halt_gate #(
    .BIT_POS (`BIT_CAN)
  ) u_gate_can (
    .halted    (halted_s),
    .hold_word (primary_r),
    .frozen    (gate_out[4])
  );

  halt_gate #(
    .BIT_POS (`BIT_WWDG)
  ) u_gate_window_watchdog (
    .halted    (halted_s),
    .hold_word (primary_r),
    .frozen    (gate_out[3])
  );

  halt_gate #(
    .BIT_POS (`BIT_FWDG)
  ) u_gate_free_watchdog (
    .halted    (halted_s),
    .hold_word (primary_r),
    .frozen    (gate_out[2])
  );

  halt_gate #(
    .BIT_POS (`BIT_LOWPOWER)
  ) u_gate_lowpower (
    .halted    (halted_s),
    .hold_word (secondary_r),
    .frozen    (gate_out[1])
  );

  halt_gate #(
    .BIT_POS (`BIT_RTC)
  ) u_gate_rtc (
    .halted    (halted_s),
    .hold_word (secondary_r),
    .frozen    (gate_out[0])
  );

  always_comb begin
    // gated by halt and hold bit alone, so counters resume once the core runs
    freeze_nxt = freeze_t'(gate_out);

    keep_nxt.keep_clock_in_sleep =
      (mode_s == mode_sleep) & primary_r[`BIT_SLEEP];
    keep_nxt.keep_clock_in_deepsleep =
      (mode_s == mode_deepsleep) & primary_r[`BIT_DEEPSLEEP];
    keep_nxt.keep_clock_in_standby =
      (mode_s == mode_standby) & primary_r[`BIT_STANDBY];
    keep_nxt.use_internal_16mhz_oscillator =
      keep_nxt.keep_clock_in_deepsleep | keep_nxt.keep_clock_in_standby;

    // remember a held standby; one pulse of reset request when it ends
    standby_seen_nxt = keep_nxt.keep_clock_in_standby;
    keep_nxt.reset_on_standby_exit =
      standby_seen_r & (mode_s != mode_standby);
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      freeze_r       <= '0;
      keep_r         <= '0;
      standby_seen_r <= 1'b0;
    end else if (clk_en) begin
      freeze_r       <= freeze_nxt;
      keep_r         <= keep_nxt;
      standby_seen_r <= standby_seen_nxt;
    end
  end

  assign freeze     = freeze_r;
  assign clock_keep = keep_r;

endmodule // debug_halt_freeze_control

// ************************************************************
// one freeze gate: a hold bit that only acts while halted
// ************************************************************
module halt_gate #(
  parameter int BIT_POS = 0
) (
  // halt state
  input  wire logic        halted,
  // hold register word
  input  wire logic [31:0] hold_word,
  // gated freeze request
  output logic             frozen
);
  // a zero hold bit leaves the unit running whatever the halt state
  assign frozen = halted & hold_word[BIT_POS];

endmodule // halt_gate

// ===== testbench/freeze_checker_assertions.sv
/* port assertions of the freeze block.
   assumes one clock and clk_en held high. */
`timescale 1ns/10ps
module freeze_checker
  import dbg_freeze_pkg::*;
(
  // clock and reset
  input wire logic        clock,
  input wire logic        rstn,
  input wire logic        clk_en,
  // register port
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [31:0] rdata,
  // state and controls
  input wire logic        core_halted,
  input wire power_mode_t power_mode,
  input wire freeze_t     freeze,
  input wire clock_keep_t clock_keep
);
  // ********
  // properties
  // ********
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_run; !core_halted [*4]; endsequence
  sequence s_clr(a); wr_stb && addr == a && wdata == 32'h0000_0000; endsequence
  a_free_unhalted: assert property (s_run |=> freeze == '0)
    else $error("freeze while running");
  a_prim_clear: assert property (s_clr(8'h04) |-> ##2 (freeze & 16'hFFDC) == '0)
    else $error("primary zero kept a freeze");
  a_sec_clear: assert property (s_clr(8'h08) |-> ##2 (freeze & 16'h0023) == '0)
    else $error("secondary zero kept a freeze");
  a_rsv_read: assert property (rd_stb && addr == 8'h04 |=> (rdata & 32'hF34E_04F8) == '0)
    else $error("reserved bits read back");
  a_unmapped_zero: assert property (rd_stb && addr > 8'h08 |=> rdata == '0)
    else $error("unmapped read not zero");
  a_keep_run: assert property (power_mode == mode_run [*4] |=> clock_keep[4:1] == '0)
    else $error("clock kept in run");
  a_pulse_one: assert property (clock_keep[0] |=> !clock_keep[0])
    else $error("exit reset longer than one cycle");
  a_osc_level: assert property (clock_keep[1] |->
    $past(power_mode, 3) == mode_deepsleep || $past(power_mode, 3) == mode_standby)
    else $error("oscillator select outside deep-sleep or standby");
endmodule // freeze_checker

bind debug_halt_freeze_control freeze_checker u_chk (.clock(clock), .rstn(rstn), .clk_en(clk_en),
  .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
  .core_halted(core_halted), .power_mode(power_mode), .freeze(freeze), .clock_keep(clock_keep));

// ===== testbench/core_timer_model.sv
/* halted core and one timer counter.
   assumes the bench asks for halt and mode. */
`timescale 1ns/10ps
module core_timer_model
  import dbg_freeze_pkg::*;
(
  input wire logic        clock,
  input wire logic        halt_req,
  input wire power_mode_t mode_req,
  input wire logic        hold,
  output logic            core_halted,
  output power_mode_t     power_mode,
  output logic [15:0]     count
);
  initial begin
    core_halted = 1'b0;
    power_mode = mode_run;
    count = 16'h0000;
  end
  // held counter keeps its value, resumes from it
  always @(posedge clock) begin
    core_halted <= halt_req;
    power_mode <= mode_req;
    if (!hold)
      count <= count + 16'h0001;
  end
endmodule // core_timer_model

// ===== testbench/debug_halt_freeze_control_tb.sv
/* self-checking bench of the freeze block.
   assumes the checker binds itself. */
`timescale 1ns/10ps
module debug_halt_freeze_control_tb;
  import dbg_freeze_pkg::*;
  logic        clock = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic [31:0] rdata;
  logic        halt_req = 1'b0;
  power_mode_t mode_req = mode_run;
  logic        core_halted;
  power_mode_t power_mode;
  freeze_t     freeze;
  clock_keep_t clock_keep;
  logic [15:0] count;
  int          errors = 0;
  int          n_checks = 0;
  int          pos[16] = '{27, 26, 23, 21, 20, 13, 12, 11, 15, 16, 17, 14, 9, 8, 16, 10};
  logic [4:0]  kx[3] = '{5'h10, 5'h0A, 5'h06};
  always #5 clock = ~clock;
  debug_halt_freeze_control dut (.clock(clock), .rstn(rstn), .clk_en(1'b1), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .core_halted(core_halted),
    .power_mode(power_mode), .freeze(freeze), .clock_keep(clock_keep));
  core_timer_model u_far (.clock(clock), .halt_req(halt_req), .mode_req(mode_req),
    .hold(freeze.freeze_tmr_zero), .core_halted(core_halted), .power_mode(power_mode),
    .count(count));
  // ********
  // tasks
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic t_regs;
    rd(8'h04, 32'h0000_0000);
    rd(8'h08, 32'h0000_0000);
    wr(8'h04, 32'hFFFF_FFFF);
    wr(8'h08, 32'hFFFF_FFFF);
    rd(8'h04, 32'h0CB1_FB07);
    rd(8'h08, 32'h0003_0400);
    rd(8'h0C, 32'h0000_0000);
    idle(4);
    chk({16'h0000, freeze}, 32'h0000_0000);
    $display("regs done");
  endtask
  task automatic t_freeze;
    logic [15:0] c;
    halt_req <= 1'b1;
    idle(6);
    chk({16'h0000, freeze}, 32'h0000_FFFF);
    c = count;
    idle(3);
    chk({16'h0000, count}, {16'h0000, c});
    for (int i = 0; i < 16; i++) begin
      wr(8'h04, 32'h0000_0000);
      wr(8'h08, 32'h0000_0000);
      wr((i inside {10, 14, 15}) ? 8'h08 : 8'h04, 32'h0000_0001 << pos[i]);
      idle(3);
      chk({16'h0000, freeze}, 32'h0000_8000 >> i);
    end
    rd(8'h08, 32'h0000_0400);
    wr(8'h04, 32'h0000_0800);
    idle(3);
    c = count;
    halt_req <= 1'b0;
    idle(6);
    chk({16'h0000, freeze}, 32'h0000_0000);
    chk({16'h0000, count}, {16'h0000, c + 16'h0002});
    c = count;
    idle(2);
    chk({16'h0000, count}, {16'h0000, c + 16'h0002});
    $display("freeze done");
  endtask
  task automatic t_clock;
    logic [31:0] p;
    wr(8'h04, 32'h0000_0007);
    for (int m = 1; m < 4; m++) begin
      mode_req <= power_mode_t'(m);
      idle(5);
      chk({27'h0, clock_keep}, {27'h0, kx[m - 1]});
    end
    mode_req <= mode_run;
    p = 32'h0000_0000;
    repeat (8) begin
      idle(1);
      p = p + {31'h0, clock_keep.reset_on_standby_exit};
    end
    chk(p, 32'h0000_0001);
    wr(8'h04, 32'h0000_0000);
    mode_req <= mode_standby;
    idle(5);
    chk({27'h0, clock_keep}, 32'h0000_0000);
    $display("clock done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    t_regs();
    t_freeze();
    t_clock();
    complete_run();
  end
  // run needs some 240 cycles
  initial begin
    #50000;
    errors++;
    complete_run();
  end
endmodule // debug_halt_freeze_control_tb
